/* File: lptc_host.sv */
// host model issuing byte accesses on the register port
`timescale 1ns/10ps
module lptc_host (
   // clock
   input wire logic clk,
   // register port
   output lptc_pkg::lptc_reg_req_t regReq,
   input wire logic [7:0] regReadData
);
   initial regReq = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regReq <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      regReq.write <= 1'b0;
      regReq.data <= ~d;
   endtask
   // threshold as low byte then high byte, near reserved bits zero
   task automatic wr2(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h01, a[3] ? {2'b00, v[13:8]} : v[15:8]);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regReq <= '{1'b0, 1'b1, a, regReq.data};
      @(posedge clk);
      regReq.read <= 1'b0;
      #1 d = regReadData;
   endtask
endmodule // lptc_host

/* File: lptc_params.svh */
// offsets, field positions, reset values and counts of the threshold bank
`ifndef LPTC_PARAMS_SVH
`define LPTC_PARAMS_SVH

`define LPTC_ADDR_LIGHT_LOW_LO 8'h84
`define LPTC_ADDR_LIGHT_LOW_HI 8'h85
`define LPTC_ADDR_LIGHT_HIGH_LO 8'h86
`define LPTC_ADDR_LIGHT_HIGH_HI 8'h87
`define LPTC_ADDR_NEAR_LOW_LO 8'h88
`define LPTC_ADDR_NEAR_LOW_HI 8'h89
`define LPTC_ADDR_NEAR_HIGH_LO 8'h8a
`define LPTC_ADDR_NEAR_HIGH_HI 8'h8b

`define LPTC_RESET_BYTE 8'h00
`define LPTC_UNMAPPED_READ 8'h00
`define LPTC_CONFIG_SIX_APC_OFF_BIT 6
`define LPTC_NEAR_HI_FIELD_MSB 5
`define LPTC_NEAR_SHORT_MSB 9
`define LPTC_NEAR_SHORT_LSB 2
`define LPTC_LIGHT_PERS_LINEAR_TOP 4'h3
`define LPTC_LIGHT_PERS_STEP 6'h05
`define LPTC_REG_COUNT 8

`endif

/* File: lptc_persist.sv */
// consecutive out-of-window counter that fires on reaching its target
`timescale 1ns/10ps
`include "lptc_params.svh"

module lptc_persist #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // one result per conversion
   input wire logic sampleValid,
   input wire logic outside,
   // target count, zero fires on every conversion
   input wire logic [5:0] target,
   // one-cycle pulse in the conversion cycle
   output logic fire
);

   generate
      if (CNT_W != 6) begin : g_bad_width
         $error("lptc_persist needs CNT_W of 6 to reach a count of 60");
      end
   endgenerate

   lptc_pkg::lptc_pers_state_t state;
   lptc_pkg::lptc_pers_state_t next_state;
   logic [5:0] bumped;

   always_comb begin
      next_state = state;
      bumped = (state.count == 6'h3f) ? state.count : state.count + 6'h01;
      fire = 1'b0;
      if (sampleValid) begin
         if (outside) begin
            next_state.count = bumped;
         end else begin
            next_state.count = 6'h00;
         end
         if (target == 6'h00) begin
            fire = 1'b1;
         end else if (outside && bumped == target &&
               state.count != target) begin
            fire = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule // lptc_persist

/* File: lptc_pkg.sv */
// types shared by the threshold bank and its persistence counters
package lptc_pkg;

   // one access from the serial register port
   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] data;
   } lptc_reg_req_t;

   // one completed conversion
   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } lptc_sample_t;

   // state of a persistence counter
   typedef struct packed {
      logic [5:0] count;
   } lptc_pers_state_t;

   // state of the threshold bank
   typedef struct packed {
      logic [7:0][7:0] regByte;
      logic [15:0] lightLowActive;
      logic [15:0] lightHighActive;
      logic [13:0] nearLowActive;
      logic [13:0] nearHighActive;
      logic [7:0] readData;
      logic lightFlag;
      logic nearFlag;
   } lptc_state_t;

endpackage

/* File: lptc_top.sv */
// light and proximity threshold registers with window compare
// What this block does
// - lower light threshold is bytes 0x84 low, 0x85 high, unsigned
// - upper light threshold is bytes 0x86 low, 0x87 high, unsigned
// - light value below lower threshold with persistence met sets light flag
// - light value above upper threshold with persistence met sets light flag
// - light flag with light enable drives the interrupt pin
// - low byte waits in a shadow; high byte write latches both together, except near bytes with auto pulse off
// - auto pulse on: lower near threshold is 0x89[5:0] over 0x88
// - auto pulse on: upper near threshold is 0x8b[5:0] over 0x8a
// - near result below lower threshold with persistence met sets near flag
// - near result above upper threshold with persistence met sets near flag
// - near flag with near enable drives the interrupt pin
// - config six bit 6 set turns auto pulse off, result is 10-bit
// - auto pulse off: low-byte registers compare with result bits 9:2
// - near out-of-window count clears inside, fires on equal to setting
// - light out-of-window count clears inside, fires on equal, up to 60
`timescale 1ns/10ps
`include "lptc_params.svh"

module lptc_top #(
   parameter int LIGHT_W = 16,
   parameter int NEAR_W = 14,
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // serial register port, already decoded to byte accesses
   input wire lptc_pkg::lptc_reg_req_t regReq,
   output logic [7:0] regReadData,
   // converter results, valid for one cycle per conversion
   input wire lptc_pkg::lptc_sample_t lightSample,
   input wire lptc_pkg::lptc_sample_t nearSample,
   // configuration held elsewhere
   input wire logic [3:0] lightPersistence,
   input wire logic [3:0] nearPersistence,
   input wire logic [7:0] configSix,
   input wire logic lightIrqEnable,
   input wire logic nearIrqEnable,
   // flag clears, one-cycle pulses
   input wire logic lightIrqClear,
   input wire logic nearIrqClear,
   // status and interrupt pin
   output logic lightIrqFlag,
   output logic nearIrqFlag,
   output logic intPin_b,
   output logic intPinOe
);

   generate
      if (LIGHT_W != 16 || NEAR_W != 14) begin : g_bad_width
         $error("lptc_top serves only 16-bit light and 14-bit near data");
      end
   endgenerate

   // byte index of a mapped address, valid flag in the top bit
   function automatic logic [3:0] regIndex(input logic [7:0] addr);
      logic [3:0] idx;
      idx = 4'h0;
      case (addr)
         `LPTC_ADDR_LIGHT_LOW_LO: idx = 4'h8;
         `LPTC_ADDR_LIGHT_LOW_HI: idx = 4'h9;
         `LPTC_ADDR_LIGHT_HIGH_LO: idx = 4'ha;
         `LPTC_ADDR_LIGHT_HIGH_HI: idx = 4'hb;
         `LPTC_ADDR_NEAR_LOW_LO: idx = 4'hc;
         `LPTC_ADDR_NEAR_LOW_HI: idx = 4'hd;
         `LPTC_ADDR_NEAR_HIGH_LO: idx = 4'he;
         `LPTC_ADDR_NEAR_HIGH_HI: idx = 4'hf;
         default: idx = 4'h0;
      endcase
      return idx;
   endfunction

   // light persistence code to consecutive count
   function automatic logic [5:0] lightTarget(input logic [3:0] code);
      logic [5:0] steps;
      steps = 6'h00;
      if (code <= `LPTC_LIGHT_PERS_LINEAR_TOP) begin
         lightTarget = {2'b00, code};
      end else begin
         steps = {2'b00, code - `LPTC_LIGHT_PERS_LINEAR_TOP};
         lightTarget = 6'(steps * `LPTC_LIGHT_PERS_STEP);
      end
   endfunction

   // register byte positions
   localparam logic [2:0] IDX_LL_LO = 3'd0;
   localparam logic [2:0] IDX_LL_HI = 3'd1;
   localparam logic [2:0] IDX_LH_LO = 3'd2;
   localparam logic [2:0] IDX_LH_HI = 3'd3;
   localparam logic [2:0] IDX_NL_LO = 3'd4;
   localparam logic [2:0] IDX_NL_HI = 3'd5;
   localparam logic [2:0] IDX_NH_LO = 3'd6;
   localparam logic [2:0] IDX_NH_HI = 3'd7;

   lptc_pkg::lptc_state_t state;
   lptc_pkg::lptc_state_t next_state;

   logic [3:0] accessIdx;
   logic accessHit;
   logic [2:0] byteIdx;
   logic apcOff;
   logic [13:0] nearValue;
   logic [13:0] nearLowCmp;
   logic [13:0] nearHighCmp;
   logic lightOutside;
   logic nearOutside;
   logic lightFire;
   logic nearFire;

   assign accessIdx = regIndex(regReq.addr);
   assign accessHit = accessIdx[3];
   assign byteIdx = accessIdx[2:0];
   assign apcOff = configSix[`LPTC_CONFIG_SIX_APC_OFF_BIT];

   // window compares on the present conversion
   always_comb begin
      nearValue = nearSample.value[13:0];
      nearLowCmp = state.nearLowActive;
      nearHighCmp = state.nearHighActive;
      if (apcOff) begin
         // short result: upper eight of ten bits against the low bytes
         nearValue = {6'h00,
            nearSample.value[`LPTC_NEAR_SHORT_MSB:`LPTC_NEAR_SHORT_LSB]};
         nearLowCmp = {6'h00, state.regByte[IDX_NL_LO]};
         nearHighCmp = {6'h00, state.regByte[IDX_NH_LO]};
      end
      lightOutside = (lightSample.value < state.lightLowActive) ||
         (lightSample.value > state.lightHighActive);
      nearOutside = (nearValue < nearLowCmp) ||
         (nearValue > nearHighCmp);
   end

   lptc_persist #(
      .CNT_W(CNT_W)
   ) u_light_persist (
      .clk(clk),
      .rst_b(rst_b),
      .sampleValid(lightSample.valid),
      .outside(lightOutside),
      .target(lightTarget(lightPersistence)),
      .fire(lightFire)
   );

   lptc_persist #(
      .CNT_W(CNT_W)
   ) u_near_persist (
      .clk(clk),
      .rst_b(rst_b),
      .sampleValid(nearSample.valid),
      .outside(nearOutside),
      .target({2'b00, nearPersistence}),
      .fire(nearFire)
   );

   always_comb begin
      next_state = state;
      // register write path
      if (regReq.write && accessHit) begin
         next_state.regByte[byteIdx] = regReq.data;
         case (byteIdx)
            IDX_LL_HI: begin
               next_state.lightLowActive =
                  {regReq.data, state.regByte[IDX_LL_LO]};
            end
            IDX_LH_HI: begin
               next_state.lightHighActive =
                  {regReq.data, state.regByte[IDX_LH_LO]};
            end
            IDX_NL_HI: begin
               next_state.nearLowActive =
                  {regReq.data[`LPTC_NEAR_HI_FIELD_MSB:0],
                   state.regByte[IDX_NL_LO]};
            end
            IDX_NH_HI: begin
               next_state.nearHighActive =
                  {regReq.data[`LPTC_NEAR_HI_FIELD_MSB:0],
                   state.regByte[IDX_NH_LO]};
            end
            default: begin
            end
         endcase
      end
      // read path, registered
      if (regReq.read) begin
         if (accessHit) begin
            next_state.readData = state.regByte[byteIdx];
         end else begin
            next_state.readData = `LPTC_UNMAPPED_READ;
         end
      end
      // sticky flags, a set beats a clear in the same cycle
      if (lightIrqClear) begin
         next_state.lightFlag = 1'b0;
      end
      if (lightFire) begin
         next_state.lightFlag = 1'b1;
      end
      if (nearIrqClear) begin
         next_state.nearFlag = 1'b0;
      end
      if (nearFire) begin
         next_state.nearFlag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state.regByte <= {`LPTC_REG_COUNT{`LPTC_RESET_BYTE}};
         state.lightLowActive <= 16'h0000;
         state.lightHighActive <= 16'h0000;
         state.nearLowActive <= 14'h0000;
         state.nearHighActive <= 14'h0000;
         state.readData <= 8'h00;
         state.lightFlag <= 1'b0;
         state.nearFlag <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign regReadData = state.readData;
   assign lightIrqFlag = state.lightFlag;
   assign nearIrqFlag = state.nearFlag;
   // open-drain pin pulled low while an enabled flag stands
   assign intPinOe = (state.lightFlag && lightIrqEnable) ||
      (state.nearFlag && nearIrqEnable);
   assign intPin_b = 1'b0;

endmodule // lptc_top

/* File: lptc_top_bench.sv */
// bench for the threshold bank driven through the host model
`timescale 1ns/10ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
   failCount++; $display("Error %s expected %h seen %h", n, e, g); end end
module lptc_top_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   lptc_pkg::lptc_reg_req_t regReq;
   logic [7:0] regReadData, rdv;
   lptc_pkg::lptc_sample_t lightSample = '0, nearSample = '0;
   logic [3:0] lightPersistence = 4'h1, nearPersistence = 4'h1;
   logic [7:0] configSix = 8'h00;
   logic lightIrqEnable = 1'b0, nearIrqEnable = 1'b0;
   logic lightIrqClear = 1'b0, nearIrqClear = 1'b0;
   logic lightIrqFlag, nearIrqFlag, intPin_b, intPinOe;
   int failCount = 0, samplesChecked = 0, cycles = 0;
   always #2 clk = ~clk;
   lptc_top lptc_top_i (.clk(clk), .rst_b(rst_b), .regReq(regReq),
      .regReadData(regReadData), .lightSample(lightSample),
      .nearSample(nearSample), .lightPersistence(lightPersistence),
      .nearPersistence(nearPersistence), .configSix(configSix),
      .lightIrqEnable(lightIrqEnable), .nearIrqEnable(nearIrqEnable),
      .lightIrqClear(lightIrqClear), .nearIrqClear(nearIrqClear),
      .lightIrqFlag(lightIrqFlag), .nearIrqFlag(nearIrqFlag),
      .intPin_b(intPin_b), .intPinOe(intPinOe));
   lptc_host lptc_host_i (.clk(clk), .regReq(regReq),
      .regReadData(regReadData));
   task automatic finalReport();
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one conversion, flags settled on return
   task automatic conv(input bit near, input logic [15:0] v);
      @(posedge clk);
      if (near) begin
         nearSample <= '{1'b1, v};
      end else begin
         lightSample <= '{1'b1, v};
      end
      @(posedge clk);
      nearSample.valid <= 1'b0;
      lightSample.valid <= 1'b0;
      #1;
   endtask
   task automatic clr();
      @(posedge clk);
      lightIrqClear <= 1'b1;
      nearIrqClear <= 1'b1;
      @(posedge clk);
      lightIrqClear <= 1'b0;
      nearIrqClear <= 1'b0;
      #1;
   endtask
   task automatic cf(input bit near, input logic [15:0] v, input logic e);
      conv(near, v);
      `CHK("flag", e, near ? nearIrqFlag : lightIrqFlag)
      clr();
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failCount++;
         finalReport();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 8'h84; a <= 8'h8b; a++) begin
         lptc_host_i.rd(8'(a), rdv);
         `CHK("reset byte", 8'h00, rdv)
      end
      $display("test reset done");
      lptc_host_i.wr2(8'h86, 16'hffff);
      lptc_host_i.wr(8'h84, 8'h34);
      cf(0, 16'h0030, 1'b0);
      lptc_host_i.wr(8'h85, 8'h12);
      cf(0, 16'h1233, 1'b1);
      cf(0, 16'h1234, 1'b0);
      lptc_host_i.wr2(8'h86, 16'h5678);
      conv(0, 16'h5679);
      `CHK("light flag", 1'b1, lightIrqFlag)
      `CHK("pin off", 1'b0, intPinOe)
      @(posedge clk);
      lightIrqEnable <= 1'b1;
      #1 `CHK("pin on", 1'b1, intPinOe)
      `CHK("pin level", 1'b0, intPin_b)
      clr();
      cf(0, 16'h5678, 1'b0);
      lptc_host_i.rd(8'h85, rdv);
      `CHK("byte back", 8'h12, rdv)
      lptc_host_i.rd(8'h8c, rdv);
      `CHK("unmapped", 8'h00, rdv)
      $display("test light done");
      @(posedge clk);
      lightPersistence <= 4'h4;
      cf(0, 16'h2000, 1'b0);
      repeat (4) cf(0, 16'h0000, 1'b0);
      cf(0, 16'h2000, 1'b0);
      repeat (4) cf(0, 16'h0000, 1'b0);
      cf(0, 16'h0000, 1'b1);
      @(posedge clk);
      lightPersistence <= 4'h0;
      cf(0, 16'h2000, 1'b1);
      $display("test persistence done");
      @(posedge clk);
      nearIrqEnable <= 1'b1;
      lptc_host_i.wr2(8'h88, 16'h0100);
      lptc_host_i.wr2(8'h8a, 16'h0200);
      cf(1, 16'h00ff, 1'b1);
      cf(1, 16'h0150, 1'b0);
      conv(1, 16'hc201);
      `CHK("near flag", 1'b1, nearIrqFlag)
      `CHK("near pin", 1'b1, intPinOe)
      clr();
      // inside result clears the run so the next outside one fires
      cf(1, 16'h0150, 1'b0);
      @(posedge clk);
      configSix <= 8'h40;
      lptc_host_i.wr(8'h88, 8'h10);
      lptc_host_i.wr(8'h8a, 8'h20);
      cf(1, 16'h003c, 1'b1);
      cf(1, 16'h0050, 1'b0);
      cf(1, 16'h0084, 1'b1);
      @(posedge clk);
      nearPersistence <= 4'h0;
      cf(1, 16'h0050, 1'b1);
      $display("test near done");
      finalReport();
   end
endmodule // lptc_top_bench
bind lptc_top lptc_top_checker lptc_top_checker_i (.clk(clk), .rst_b(rst_b),
   .regReq(regReq), .regReadData(regReadData), .lightSample(lightSample),
   .nearSample(nearSample), .lightPersistence(lightPersistence),
   .nearPersistence(nearPersistence), .lightIrqEnable(lightIrqEnable),
   .nearIrqEnable(nearIrqEnable), .lightIrqClear(lightIrqClear),
   .lightIrqFlag(lightIrqFlag), .nearIrqFlag(nearIrqFlag),
   .intPinOe(intPinOe));

/* File: lptc_top_checker.sv */
// assertions on the threshold bank ports
`timescale 1ns/10ps
module lptc_top_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire lptc_pkg::lptc_reg_req_t regReq,
   input wire logic [7:0] regReadData,
   // conversions and settings
   input wire lptc_pkg::lptc_sample_t lightSample,
   input wire lptc_pkg::lptc_sample_t nearSample,
   input wire logic [3:0] lightPersistence,
   input wire logic [3:0] nearPersistence,
   input wire logic lightIrqEnable,
   input wire logic nearIrqEnable,
   input wire logic lightIrqClear,
   // status
   input wire logic lightIrqFlag,
   input wire logic nearIrqFlag,
   input wire logic intPinOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_PIN_LIGHT: assert property (
      lightIrqFlag && lightIrqEnable |-> intPinOe)
      else $error("pin idle with light flag");
   AST_PIN_NEAR: assert property (
      nearIrqFlag && nearIrqEnable |-> intPinOe)
      else $error("pin idle with near flag");
   AST_PIN_IDLE: assert property (
      !(lightIrqFlag && lightIrqEnable) &&
      !(nearIrqFlag && nearIrqEnable) |-> !intPinOe)
      else $error("pin driven without cause");
   AST_LIGHT_HOLD: assert property (
      lightIrqFlag && !lightIrqClear |=> lightIrqFlag)
      else $error("light flag dropped");
   AST_LIGHT_CAUSE: assert property (
      $rose(lightIrqFlag) |-> $past(lightSample.valid))
      else $error("light flag without conversion");
   AST_NEAR_CAUSE: assert property (
      $rose(nearIrqFlag) |-> $past(nearSample.valid))
      else $error("near flag without conversion");
   AST_LIGHT_EVERY: assert property (
      lightSample.valid && lightPersistence == 4'h0 |=> lightIrqFlag)
      else $error("light code zero missed");
   AST_NEAR_EVERY: assert property (
      nearSample.valid && nearPersistence == 4'h0 |=> nearIrqFlag)
      else $error("near code zero missed");
   AST_READ_HOLD: assert property (
      !regReq.read |=> $stable(regReadData))
      else $error("read data moved");
   AST_UNMAPPED: assert property (
      regReq.read && regReq.addr > 8'h8b |=> regReadData == 8'h00)
      else $error("unmapped read not zero");
   cover property ($rose(lightIrqFlag));
   cover property ($rose(nearIrqFlag));
   cover property ($rose(intPinOe));
endmodule // lptc_top_checker
